// [hdl/mqoc_pkg.sv]
// shared constants and types for the multi-queue output port control
package mqoc_pkg;

	// ----------------------------------------------------------------
	// bus widths and port ranges
	// ----------------------------------------------------------------
	localparam int            DATA_W      = 36;
	localparam int            QADDR_W     = 5;
	localparam int            ID_W        = 3;
	localparam int            QSEL_W      = 2;
	localparam int            NUM_QUEUES  = 4;
	localparam int            APB_AW      = 12;
	localparam int            APB_DW      = 32;

	// ----------------------------------------------------------------
	// port width codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MQOC_W9,
		MQOC_W18,
		MQOC_W36
	} mqoc_width_t;

	localparam logic [DATA_W-1:0] MASK_X9  = 36'h0000001ff;
	localparam logic [DATA_W-1:0] MASK_X18 = 36'h00003ffff;
	localparam logic [DATA_W-1:0] MASK_X36 = 36'hfffffffff;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [APB_AW-1:0] OFS_CTRL = 12'h000;
	localparam logic [APB_AW-1:0] OFS_STAT = 12'h004;
	localparam logic [APB_AW-1:0] OFS_CFG  = 12'h008;

	// ctrl fields
	localparam int CTRL_PROG_DONE = 0;

	// status fields
	localparam int STAT_PROG_DONE = 0;
	localparam int STAT_OWNER     = 1;
	localparam int STAT_DISCARD   = 2;
	localparam int STAT_QUEUE_LSB = 3;
	localparam int STAT_OV_N      = 5;
	localparam int STAT_OV_DRIVE  = 6;
	localparam int STAT_IN_RESET  = 7;

	// cfg fields (values latched at master reset)
	localparam int CFG_MASTER     = 0;
	localparam int CFG_IN_W_LSB   = 1;
	localparam int CFG_OUT_W_LSB  = 3;
	localparam int CFG_ID_LSB     = 5;
	localparam int CFG_BM         = 8;

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic              RST_PROG_DONE = 1'b0;
	localparam logic              RST_MASTER    = 1'b1;
	localparam logic [ID_W-1:0]   RST_ID        = 3'h0;
	localparam logic [QSEL_W-1:0] RST_QUEUE     = 2'h0;
	localparam logic              RST_OV_N      = 1'b1;
	localparam int                OV_STAGES     = 2;

endpackage : mqoc_pkg

// [hdl/mqoc_width_decode.sv]
// decode of the latched width straps into port width codes
`timescale 1ns/1ps
module mqoc_width_decode
	import mqoc_pkg::*;
(
	input  wire logic        in_sel,
	input  wire logic        out_sel,
	input  wire logic        match_sel,
	output mqoc_width_t      in_width,
	output mqoc_width_t      out_width
);

	// ----------------------------------------------------------------
	// width table
	// ----------------------------------------------------------------
	// RULE1 width combination decode
	always_comb begin
		in_width  = MQOC_W36;
		out_width = MQOC_W36;
		if (match_sel) begin
			case ({in_sel, out_sel})
				2'b00: in_width  = MQOC_W18;
				2'b10: in_width  = MQOC_W9;
				2'b01: out_width = MQOC_W18;
				2'b11: out_width = MQOC_W9;
				default: begin
					in_width  = MQOC_W36;
					out_width = MQOC_W36;
				end
			endcase
		end
	end

endmodule : mqoc_width_decode

// [hdl/mqoc_flag_pipe.sv]
// two-stage delay line for the output valid flag and its drive enable
`timescale 1ns/1ps
module mqoc_flag_pipe
	import mqoc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        valid_n_in,
	input  wire logic        drive_in,
	output logic             valid_n_out,
	output logic             drive_out
);

	logic [1:0] stage_q [OV_STAGES];
	logic [1:0] stage_d [OV_STAGES];

	// ----------------------------------------------------------------
	// stages
	// ----------------------------------------------------------------
	// RULE10 delay matches data path
	for (genvar s = 0; s < OV_STAGES; s++) begin : g_stage
		if (s == 0) begin : g_first
			assign stage_d[s] = clk_en ? {drive_in, valid_n_in} : stage_q[s];
		end else begin : g_next
			assign stage_d[s] = clk_en ? stage_q[s-1] : stage_q[s];
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				stage_q[s] <= {1'b0, RST_OV_N};
			end else begin
				stage_q[s] <= stage_d[s];
			end
		end
	end

	assign valid_n_out = stage_q[OV_STAGES-1][0];
	assign drive_out   = stage_q[OV_STAGES-1][1];

endmodule : mqoc_flag_pipe

// [hdl/mqoc_output_ctrl.sv]
// read-side output control of a chained multi-queue flow-control device
//
// Operation
// RULE1: port widths come from the input, output and bus matching straps; one port is x36.
// RULE2: master_select sampled in master reset makes the device chain master when high.
// RULE3: after master reset the master drives shared outputs first and slaves stay floating.
// RULE4: a lone device must have master_select held high by the board.
// RULE5: a master reset is chip_reset_n going from high to low and back to high.
// RULE6: after each master reset software programs the device before queue operation.
// RULE7: discard_queue_select with a read address selects the discard queue, not storage.
// RULE8: on the master qout_drive_enable_n drives or floats read_data_out without a clock.
// RULE9: a slave floats read_data_out until selected, then qout_drive_enable_n governs it.
// RULE10: output_valid_n shows the newly selected queue two read clocks after selection.
// RULE11: a selected queue read to empty makes output_valid_n high.
// RULE12: output_valid_n can float so that chained valid flags share one line.
// RULE13: the upper three read address bits select the device by chain_position_code.
// RULE14: straps are captured at master reset release and held until the next one.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module mqoc_output_ctrl
	import mqoc_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                clk_en,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [APB_AW-1:0]   paddr,
	input  wire logic [APB_DW-1:0]   pwdata,
	output logic      [APB_DW-1:0]   prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                chip_reset_n,
	input  wire logic                master_select,
	input  wire logic                input_width_select,
	input  wire logic                output_width_select,
	input  wire logic                bus_matching_select,
	input  wire logic [ID_W-1:0]     chain_position_code,
	input  wire logic [QADDR_W-1:0]  read_queue_address,
	input  wire logic                read_address_enable,
	input  wire logic                discard_queue_select,
	input  wire logic                qout_drive_enable_n,
	input  wire logic [NUM_QUEUES-1:0] queue_empty,
	input  wire logic [DATA_W-1:0]   read_data_in,
	output logic      [DATA_W-1:0]   read_data_out,
	output logic                     read_data_oe,
	output logic                     output_valid_n,
	output logic                     output_valid_oe,
	output logic      [QSEL_W-1:0]   selected_queue,
	output logic                     discard_selected,
	output mqoc_width_t              in_width,
	output mqoc_width_t              out_width
);

	// ----------------------------------------------------------------
	// strap capture
	// ----------------------------------------------------------------
	logic            cfg_master_q, cfg_master_d;
	logic            cfg_iw_q,     cfg_iw_d;
	logic            cfg_ow_q,     cfg_ow_d;
	logic            cfg_bm_q,     cfg_bm_d;
	logic [ID_W-1:0] cfg_id_q,     cfg_id_d;

	// straps track the pins while reset is low, so the last value before release sticks
	always_comb begin
		cfg_master_d = cfg_master_q;
		cfg_iw_d     = cfg_iw_q;
		cfg_ow_d     = cfg_ow_q;
		cfg_bm_d     = cfg_bm_q;
		cfg_id_d     = cfg_id_q;
		// RULE14 capture at reset release
		if (clk_en && !chip_reset_n) begin
			// RULE2 master or slave
			cfg_master_d = master_select;
			cfg_iw_d     = input_width_select;
			cfg_ow_d     = output_width_select;
			cfg_bm_d     = bus_matching_select;
			cfg_id_d     = chain_position_code;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_master_q <= RST_MASTER;
			cfg_iw_q     <= 1'b0;
			cfg_ow_q     <= 1'b0;
			cfg_bm_q     <= 1'b0;
			cfg_id_q     <= RST_ID;
		end else begin
			cfg_master_q <= cfg_master_d;
			cfg_iw_q     <= cfg_iw_d;
			cfg_ow_q     <= cfg_ow_d;
			cfg_bm_q     <= cfg_bm_d;
			cfg_id_q     <= cfg_id_d;
		end
	end

	mqoc_width_decode u_width (
		.in_sel    (cfg_iw_q),
		.out_sel   (cfg_ow_q),
		.match_sel (cfg_bm_q),
		.in_width  (in_width),
		.out_width (out_width)
	);

	// ----------------------------------------------------------------
	// read port selection
	// ----------------------------------------------------------------
	logic              prog_done_q, prog_done_d;
	logic              owner_q,     owner_d;
	logic              discard_q,   discard_d;
	logic [QSEL_W-1:0] queue_q,     queue_d;
	logic              sel_take;
	logic              id_match;
	logic              prog_set;

	// RULE13 device match on upper address bits
	assign id_match = read_queue_address[QADDR_W-1 -: ID_W] == cfg_id_q;
	// RULE6 selection only once programmed
	assign sel_take = clk_en && chip_reset_n && prog_done_q && read_address_enable;

	always_comb begin
		owner_d     = owner_q;
		discard_d   = discard_q;
		queue_d     = queue_q;
		prog_done_d = prog_done_q;
		if (clk_en && prog_set) begin
			prog_done_d = 1'b1;
		end
		if (clk_en && !chip_reset_n) begin
			// RULE3 master takes the shared outputs first
			owner_d     = cfg_master_d;
			discard_d   = 1'b0;
			queue_d     = RST_QUEUE;
			prog_done_d = RST_PROG_DONE;
		end else if (sel_take) begin
			// RULE9 slave owns outputs only once selected
			owner_d = id_match;
			if (id_match) begin
				// RULE7 discard queue selection
				discard_d = discard_queue_select;
				queue_d   = read_queue_address[QSEL_W-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			owner_q     <= RST_MASTER;
			discard_q   <= 1'b0;
			queue_q     <= RST_QUEUE;
			prog_done_q <= RST_PROG_DONE;
		end else begin
			owner_q     <= owner_d;
			discard_q   <= discard_d;
			queue_q     <= queue_d;
			prog_done_q <= prog_done_d;
		end
	end

	assign selected_queue   = queue_q;
	assign discard_selected = discard_q;

	// ----------------------------------------------------------------
	// data output
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] rd_data_q, rd_data_d;
	logic [DATA_W-1:0] out_mask;

	always_comb begin
		case (out_width)
			MQOC_W9:  out_mask = MASK_X9;
			MQOC_W18: out_mask = MASK_X18;
			default:  out_mask = MASK_X36;
		endcase
		rd_data_d = clk_en ? (read_data_in & out_mask) : rd_data_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data_q <= '0;
		end else begin
			rd_data_q <= rd_data_d;
		end
	end

	assign read_data_out = rd_data_q;
	// RULE8 enable is a plain gate, no clock involved
	assign read_data_oe  = owner_q && chip_reset_n && !qout_drive_enable_n;

	// ----------------------------------------------------------------
	// output valid flag
	// ----------------------------------------------------------------
	logic ov_raw_n;
	logic ov_drive;

	// RULE11 empty or discard queue reads as invalid
	assign ov_raw_n = discard_q || queue_empty[queue_q];

	mqoc_flag_pipe u_ov_pipe (
		.pclk        (pclk),
		.presetn     (presetn),
		.clk_en      (clk_en),
		.valid_n_in  (ov_raw_n),
		.drive_in    (owner_q),
		.valid_n_out (output_valid_n),
		.drive_out   (ov_drive)
	);

	// RULE12 deselected devices float the shared flag
	assign output_valid_oe = ov_drive;

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	logic [APB_DW-1:0] prdata_q, prdata_d;
	logic              addr_ok;
	logic              setup;

	assign addr_ok  = paddr == OFS_CTRL || paddr == OFS_STAT || paddr == OFS_CFG;
	assign setup    = psel && !penable;
	assign pready   = clk_en;
	assign pslverr  = psel && penable && !addr_ok;
	assign prog_set = psel && penable && pwrite && paddr == OFS_CTRL && pwdata[CTRL_PROG_DONE];
	assign prdata   = prdata_q;

	// read data is staged in the setup cycle so prdata comes from a flop
	always_comb begin
		prdata_d = prdata_q;
		if (clk_en && setup) begin
			prdata_d = '0;
			case (paddr)
				OFS_CTRL: prdata_d[CTRL_PROG_DONE] = prog_done_q;
				OFS_STAT: begin
					prdata_d[STAT_PROG_DONE]                = prog_done_q;
					prdata_d[STAT_OWNER]                    = owner_q;
					prdata_d[STAT_DISCARD]                  = discard_q;
					prdata_d[STAT_QUEUE_LSB +: QSEL_W]      = queue_q;
					prdata_d[STAT_OV_N]                     = output_valid_n;
					prdata_d[STAT_OV_DRIVE]                 = ov_drive;
					prdata_d[STAT_IN_RESET]                 = !chip_reset_n;
				end
				OFS_CFG: begin
					prdata_d[CFG_MASTER]        = cfg_master_q;
					prdata_d[CFG_IN_W_LSB +: 2] = in_width;
					prdata_d[CFG_OUT_W_LSB +: 2] = out_width;
					prdata_d[CFG_ID_LSB +: ID_W] = cfg_id_q;
					prdata_d[CFG_BM]            = cfg_bm_q;
				end
				default: prdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else begin
			prdata_q <= prdata_d;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_width_one_x36: assert property ( // RULE1
		@(posedge pclk) disable iff (!presetn)
		(in_width == MQOC_W36) || (out_width == MQOC_W36))
		else $error("neither port is x36");

	chk_width_table: assert property ( // RULE1
		@(posedge pclk) disable iff (!presetn)
		cfg_bm_q ? ((out_width != MQOC_W36) == cfg_ow_q) : (in_width == out_width))
		else $error("width table broken");

	chk_master_capture: assert property ( // RULE2
		@(posedge pclk) disable iff (!presetn)
		(clk_en && !chip_reset_n) |=> cfg_master_q == $past(master_select))
		else $error("master strap not captured");

	chk_slave_quiet: assert property ( // RULE3
		@(posedge pclk) disable iff (!presetn)
		$rose(chip_reset_n) && !cfg_master_q |-> !read_data_oe && !output_valid_oe)
		else $error("slave drives after master reset");

	chk_discard_select: assert property ( // RULE7
		@(posedge pclk) disable iff (!presetn)
		sel_take && id_match && discard_queue_select |=> discard_q && owner_q)
		else $error("discard queue not selected");

	chk_oe_async: assert property ( // RULE8
		@(posedge pclk) disable iff (!presetn)
		owner_q && chip_reset_n |-> read_data_oe == !qout_drive_enable_n)
		else $error("data enable ignores drive enable");

	chk_slave_float: assert property ( // RULE9
		@(posedge pclk) disable iff (!presetn)
		!owner_q |-> !read_data_oe)
		else $error("unselected device drives data");

	chk_ov_delay: assert property ( // RULE10
		@(posedge pclk) disable iff (!presetn)
		$past(presetn) && $past(presetn, 2) && $past(clk_en) && $past(clk_en, 2)
		|-> output_valid_n == $past(ov_raw_n, 2))
		else $error("valid flag delay wrong");

	chk_empty_ov: assert property ( // RULE11
		@(posedge pclk) disable iff (!presetn)
		clk_en [*2] ##0 (queue_empty[queue_q] && $stable(queue_q) && $stable(queue_empty))
		##1 clk_en |-> output_valid_n)
		else $error("empty queue flagged valid");

	chk_ov_float: assert property ( // RULE12
		@(posedge pclk) disable iff (!presetn)
		$past(clk_en) && $past(clk_en, 2) && $past(!owner_q, 2) |-> !output_valid_oe)
		else $error("valid flag driven while deselected");

	chk_id_select: assert property ( // RULE13
		@(posedge pclk) disable iff (!presetn)
		sel_take && !id_match |=> !owner_q)
		else $error("device kept outputs on other id");

	chk_cfg_hold: assert property ( // RULE14
		@(posedge pclk) disable iff (!presetn)
		chip_reset_n |=> $stable(cfg_master_q) && $stable(cfg_id_q) && $stable(cfg_bm_q))
		else $error("straps changed outside master reset");

endmodule : mqoc_output_ctrl

// [test/mqoc_rd_ctrl.sv]
// read-side controller model that issues queue selections on the read port
`timescale 1ns/1ps
module mqoc_rd_ctrl
	import mqoc_pkg::*;
(
	input  wire logic               pclk,
	input  wire logic               req,
	input  wire logic [QADDR_W-1:0] req_addr,
	input  wire logic               req_discard,
	output logic      [QADDR_W-1:0] read_queue_address,
	output logic                    read_address_enable,
	output logic                    discard_queue_select
);
	// one-cycle selection request, changed just after the edge
	always @(posedge pclk) begin
		if (req) begin
			read_address_enable  <= 1'b1;
			read_queue_address   <= req_addr;
			discard_queue_select <= req_discard;
		end else begin
			read_address_enable  <= 1'b0;
			discard_queue_select <= 1'b0;
			// idle address toggles so a stale value cannot look valid
			read_queue_address   <= ~read_queue_address;
		end
	end
endmodule : mqoc_rd_ctrl

// [test/tb.sv]
// self-checking bench for the read-side output control
`timescale 1ns/1ps
module tb
	import mqoc_pkg::*;
;
	typedef struct packed {
		logic [4:0] addr;
		logic       disc;
		logic [3:0] empty;
		logic [1:0] q;
		logic       dsel;
		logic       ovn;
		logic       own;
		logic       care;
	} mqoc_row_t;

	logic                  pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
	logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [APB_AW-1:0]     paddr = 12'h000;
	logic [APB_DW-1:0]     pwdata = 32'h00000000, prdata, rd;
	logic                  pready, pslverr, err, chip_reset_n = 1'b1, master_select = 1'b1;
	logic                  input_width_select = 1'b0, output_width_select = 1'b0;
	logic                  bus_matching_select = 1'b0, qout_drive_enable_n = 1'b1;
	logic [ID_W-1:0]       chain_position_code = 3'h2;
	logic [QADDR_W-1:0]    read_queue_address, req_addr = 5'h00;
	logic                  read_address_enable, discard_queue_select;
	logic                  req = 1'b0, req_discard = 1'b0, prev_oe, prev_ovn;
	logic [NUM_QUEUES-1:0] queue_empty = 4'h0;
	logic [DATA_W-1:0]     read_data_in = 36'h000000000, read_data_out;
	logic                  read_data_oe, output_valid_n, output_valid_oe, discard_selected;
	logic [QSEL_W-1:0]     selected_queue;
	mqoc_width_t           in_width, out_width;
	int                    failures = 0, samples_checked = 0, cycles = 0;
	// device id is 2; last row addresses id 5
	mqoc_row_t             rows [5] = '{
		'{5'h0b, 1'b0, 4'h8, 2'h3, 1'b0, 1'b1, 1'b1, 1'b1},
		'{5'h08, 1'b0, 4'h8, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1},
		'{5'h0a, 1'b1, 4'h8, 2'h2, 1'b1, 1'b1, 1'b1, 1'b1},
		'{5'h09, 1'b0, 4'h8, 2'h1, 1'b0, 1'b0, 1'b1, 1'b1},
		'{5'h15, 1'b0, 4'h8, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0}};

	always #12.5 pclk = ~pclk;

	mqoc_output_ctrl uut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .chip_reset_n, .master_select,
		.input_width_select, .output_width_select, .bus_matching_select,
		.chain_position_code, .read_queue_address, .read_address_enable,
		.discard_queue_select, .qout_drive_enable_n, .queue_empty, .read_data_in,
		.read_data_out, .read_data_oe, .output_valid_n, .output_valid_oe,
		.selected_queue, .discard_selected, .in_width, .out_width);

	mqoc_rd_ctrl ctl (.pclk, .req, .req_addr, .req_discard, .read_queue_address,
		.read_address_enable, .discard_queue_select);

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish;
		if (failures == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic mreset(input logic ms, input logic iw, input logic ow, input logic bm);
		@(posedge pclk);
		chip_reset_n        <= 1'b0;
		master_select       <= ms;
		input_width_select  <= iw;
		output_width_select <= ow;
		bus_matching_select <= bm;
		repeat (2) @(posedge pclk);
		#1 chk(read_data_oe, 1'b0);
		@(posedge pclk);
		chip_reset_n <= 1'b1;
		@(posedge pclk);
	endtask : mreset

	task automatic sel(input logic [4:0] a, input logic dq, input logic [3:0] em);
		@(posedge pclk);
		req         <= 1'b1;
		req_addr    <= a;
		req_discard <= dq;
		queue_empty <= em;
		@(posedge pclk);
		req <= 1'b0;
		@(posedge pclk);
		#1;
	endtask : sel

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge pclk);
		#1 chk(output_valid_n, 1'b1);
		chk(output_valid_oe, 1'b0);
		chk(out_width, MQOC_W36);
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		qout_drive_enable_n <= 1'b0;
		#1 chk(read_data_oe, 1'b1);
		@(posedge pclk);
		qout_drive_enable_n <= 1'b1;
		#1 chk(read_data_oe, 1'b0);
		mreset(1'b1, 1'b0, 1'b0, 1'b0);
		// straps moving after release must not reach the config
		master_select <= 1'b0;
		qout_drive_enable_n <= 1'b0;
		apb(1'b0, OFS_CFG, 32'h00000000);
		chk(rd, 32'h00000055);
		sel(5'h0b, 1'b0, 4'h0);
		chk(selected_queue, 2'h0);
		apb(1'b1, OFS_CTRL, 32'h00000001);
		apb(1'b0, OFS_CTRL, 32'h00000000);
		chk(rd, 32'h00000001);
		apb(1'b0, 12'h00c, 32'h00000000);
		chk(err, 1'b1);
		chk(rd, 32'h00000000);
		prev_oe = 1'b1;
		prev_ovn = 1'b0;
		foreach (rows[i]) begin
			sel(rows[i].addr, rows[i].disc, rows[i].empty);
			chk(selected_queue, rows[i].q);
			chk(read_data_oe, rows[i].own);
			if (rows[i].care)
				chk(discard_selected, rows[i].dsel);
			@(posedge pclk);
			#1 chk(output_valid_oe, prev_oe);
			if (rows[i].care)
				chk(output_valid_n, prev_ovn);
			@(posedge pclk);
			#1 chk(output_valid_oe, rows[i].own);
			if (rows[i].care)
				chk(output_valid_n, rows[i].ovn);
			prev_oe = rows[i].own;
			prev_ovn = rows[i].ovn;
		end
		mreset(1'b0, 1'b0, 1'b1, 1'b1);
		#1 chk(out_width, MQOC_W18);
		chk(in_width, MQOC_W36);
		chk(read_data_oe, 1'b0);
		apb(1'b0, OFS_CTRL, 32'h00000000);
		chk(rd, 32'h00000000);
		apb(1'b0, OFS_STAT, 32'h00000000);
		chk(rd & 32'h00000002, 32'h00000000);
		apb(1'b1, OFS_CTRL, 32'h00000001);
		read_data_in <= 36'hfffffffff;
		sel(5'h08, 1'b0, 4'h0);
		chk(read_data_oe, 1'b1);
		chk(read_data_out, 36'h00003ffff);
		@(posedge pclk);
		qout_drive_enable_n <= 1'b1;
		#1 chk(read_data_oe, 1'b0);
		// frozen clock enable must hold the selection and the bus answer
		@(posedge pclk);
		clk_en   <= 1'b0;
		req      <= 1'b1;
		req_addr <= 5'h0b;
		repeat (3) @(posedge pclk);
		#1 chk(selected_queue, 2'h0);
		chk(pready, 1'b0);
		@(posedge pclk);
		clk_en <= 1'b1;
		req    <= 1'b0;
		@(posedge pclk);
		#1 chk(selected_queue, 2'h3);
		tally_and_finish();
	end
endmodule : tb
